// File: coefficient_ram_block_addressing_bench.sv
`timescale 1ns/10ps
module coefficient_ram_block_addressing_bench import crb_pkg::*;;
  logic sys_clk = 1'b0, srst = 1'b1, cmd_valid, cmd_ready, rd_valid, cmd_rejected, wr_ready;
  crb_cmd_t cmd;
  logic [15:0] wr_data, rd_data, g, f, t;
  logic [5:0] word_addr;
  int bad_count = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  crb_host i_crb_host (.sys_clk, .cmd_ready, .wr_ready, .cmd_valid, .cmd, .wr_data);
  crb_coeff_ram i_crb_coeff_ram (.sys_clk, .srst, .cmd_valid, .cmd, .cmd_ready, .wr_data,
    .wr_ready, .rd_data, .rd_valid, .word_addr, .word_strobe(), .busy(), .cmd_rejected,
    .receive_gain_coeff_word(g), .receive_freq_response_coeff_word(f),
    .block3_top_coeff_word(t));
  task automatic chk(string n, logic [15:0] e, logic [15:0] v);
    num_checks++;
    if (v !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One command, then the whole walk; reads judged word by word
  // Written words carry tag and address; unwritten ones read zero
  task automatic run(logic w, logic [2:0] b, logic full);
    i_crb_host.go(w, b);
    @(negedge sys_clk);
    chk("rej", {15'h0, b > 3'h4}, {15'h0, cmd_rejected});
    for (int k = 7; k >= 0; k--) begin
      @(negedge sys_clk);
      if (!w) chk("addr", {10'h1, b, 3'(k)}, {9'h0, rd_valid, word_addr});
      if (!w) chk("data", full ? {10'h1a5, b, 3'(k)} : 16'h0, rd_data);
    end
    @(negedge sys_clk);
    chk("end", 16'h0, {15'h0, rd_valid});
  endtask
  // Receive pair and tone block words land where expected
  task automatic t_map;
    run(1'b1, 3'h4, 1'b0);
    run(1'b1, 3'h2, 1'b0);
    chk("gain", {10'h1a5, CRB_ADDR_RX_GAIN}, g);
    chk("fresp", {10'h1a5, CRB_ADDR_RX_FRESP}, f);
    chk("top", {10'h1a5, CRB_ADDR_BLK3_TOP}, t);
    run(1'b0, 3'h4, 1'b1);
  endtask
  // Blocks above four are refused and change nothing
  task automatic t_rej;
    for (int b = 5; b < 8; b++) run(1'b1, 3'(b), 1'b0);
    chk("gain", {10'h1a5, CRB_ADDR_RX_GAIN}, g);
    run(1'b0, 3'h4, 1'b1);
    run(1'b0, 3'h0, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    t_map;
    t_rej;
    complete_run;
  end
  // Whole run is about 110 cycles; cut a hang well past that
  initial begin
    #2us;
    bad_count++;
    complete_run;
  end
endmodule // coefficient_ram_block_addressing_bench

// File: crb_chk.sv
`timescale 1ns/10ps
// Walk seen at the top ports
module crb_chk import crb_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input crb_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic [5:0] word_addr,
  input wire logic word_strobe,
  input wire logic busy,
  input wire logic cmd_rejected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire tk = cmd_valid && cmd_ready && cmd.blk < 3'h5;
  sequence s_w; busy [*8] ##1 !busy; endsequence
  // Length, order and refusal of a walk
  property p_w; tk |=> s_w; endproperty
  a_w: assert property (p_w) else $error("walk");
  property p_t; tk |=> ##1 word_addr == {$past(cmd.blk, 2), 3'h7}; endproperty
  a_t: assert property (p_t) else $error("top");
  property p_d; word_strobe && |word_addr[2:0] |=> word_addr == $past(word_addr) - 6'h1; endproperty
  a_d: assert property (p_d) else $error("down");
  property p_x; word_addr == 6'h27 |=> word_addr == 6'h26; endproperty
  a_x: assert property (p_x) else $error("pair");
  property p_r; cmd_valid && cmd_ready && !tk |=> cmd_rejected && !busy; endproperty
  a_r: assert property (p_r) else $error("refuse");
  property p_g; word_strobe |-> word_addr < 6'h28; endproperty
  a_g: assert property (p_g) else $error("range");
  property p_b; busy |-> !cmd_ready && !cmd_rejected; endproperty
  a_b: assert property (p_b) else $error("ready");
  property p_s; tk |=> ##1 word_strobe [*8] ##1 !word_strobe; endproperty
  a_s: assert property (p_s) else $error("strobe");
endmodule // crb_chk
bind crb_coeff_ram crb_chk i_crb_chk (.sys_clk, .srst, .cmd_valid, .cmd, .cmd_ready,
  .word_addr, .word_strobe, .busy, .cmd_rejected);

// File: crb_coeff_ram.sv
`timescale 1ns/10ps
// Function
// R01: Coefficient memory holds 40 words, five blocks of eight.
// R02: Command names a block by three bits, never a single word.
// R03: One command walks all eight words of the named block.
// R04: Word index counts down 7 to 0, highest word first.
// R05: Word address is block number above, word index below.
// R06: Receive gain access always also reaches receive frequency response.
// R07: Block 4 holds receive gain at 39, frequency response at 38.
// R08: Block 2 holds its top coefficient at word 19.
// R09: Blocks 5 to 7 are ignored and leave the memory untouched.
module crb_coeff_ram
  import crb_pkg::*;
#(
  parameter int unsigned DATA_W = CRB_DATA_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input crb_cmd_t cmd,
  output logic cmd_ready,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic [CRB_ADDR_W-1:0] word_addr,
  output logic word_strobe,
  output logic busy,
  output logic cmd_rejected,
  output logic [DATA_W-1:0] receive_gain_coeff_word,
  output logic [DATA_W-1:0] receive_freq_response_coeff_word,
  output logic [DATA_W-1:0] block3_top_coeff_word
);

  // Walk state and the command captured at take
  crb_state_t state_r;
  logic [CRB_BLK_W-1:0] blk_r;
  logic [CRB_IDX_W-1:0] idx_r;
  logic wr_r;

  // Storage, one entry per coefficient word
  logic [DATA_W-1:0] mem_r [CRB_WORDS];

  // Decoded handshake and walk events
  logic legal;
  logic cmd_take;
  logic cmd_refuse;
  logic walk_last;
  logic wr_en;
  logic rd_en;
  logic [CRB_ADDR_W-1:0] addr;
  logic [CRB_WORDS-1:0] word_sel;
  logic [DATA_W-1:0] rd_word;

  // Only blocks 0..4 exist; a higher number is refused at the door,
  // so a walk can never form an address past the last word
  assign legal = (cmd.blk <= CRB_BLK_LAST); // R09

  // Ready only while idle; an offer during a walk just waits
  assign cmd_ready = (state_r == CRB_IDLE);
  assign busy = (state_r == CRB_RUN);

  // An offer counts only on an edge where ready is high
  assign cmd_take = cmd_valid && cmd_ready && legal; // R02
  assign cmd_refuse = cmd_valid && cmd_ready && !legal; // R09

  // The walk ends on the word with index zero
  assign walk_last = busy && (idx_r == CRB_IDX_BOT); // R03

  // Direction of the current walk, fixed at take
  assign wr_en = busy && wr_r;
  assign rd_en = busy && !wr_r;
  assign wr_ready = wr_en;

  // Block number on top, counted index below
  assign addr = {blk_r, idx_r}; // R05

  // Per-word select; codes 40..63 match no entry, so nothing is written
  for (genvar gi = 0; gi < CRB_WORDS; gi++) begin : g_sel
    assign word_sel[gi] = (addr == CRB_ADDR_W'(gi)); // R01
  end

  // Word at the walk address; blk_r only ever holds a legal block,
  // so this index stays inside the array even between walks
  assign rd_word = mem_r[addr];

  // Walk state: idle until a legal block is taken, back after 8 words
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= CRB_IDLE;
    end else begin
      unique case (state_r)
        CRB_IDLE: begin
          if (cmd_take) begin
            state_r <= CRB_RUN;
          end
        end
        CRB_RUN: begin
          // Eight words, no host addressing; gain and response go together
          if (walk_last) begin // R03 R06
            state_r <= CRB_IDLE;
          end
        end
      endcase
    end
  end

  // Block number, held for the whole walk; the host sends no word number
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      blk_r <= '0;
    end else if (cmd_take) begin
      blk_r <= cmd.blk; // R02
    end
  end

  // Walk direction, taken together with the block
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_r <= 1'b0;
    end else if (cmd_take) begin
      wr_r <= cmd.wr;
    end
  end

  // Word index: loaded at the top, one step down per walk cycle;
  // it wraps back to the top on the last word, ready for the next walk
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idx_r <= CRB_IDX_TOP;
    end else if (cmd_take) begin
      idx_r <= CRB_IDX_TOP; // R04
    end else if (busy) begin
      idx_r <= idx_r - 3'h1; // R04
    end
  end

  // Refusal pulse for blocks 5..7, one cycle; nothing else moves
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_rejected <= 1'b0;
    end else begin
      cmd_rejected <= cmd_refuse; // R09
    end
  end

  // Storage: cleared on reset, one word per write-walk cycle. There is
  // no write path outside a walk, so a refused block cannot touch it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < CRB_WORDS; i++) begin
        mem_r[i] <= DATA_W'(CRB_DATA_RST); // R01
      end
    end else begin
      for (int i = 0; i < CRB_WORDS; i++) begin
        if (wr_en && word_sel[i]) begin
          mem_r[i] <= wr_data;
        end
      end
    end
  end

  // Read word valid, one cycle after each read-walk access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en; // R03
    end
  end

  // Walk word; zero between walks so stale data never lingers.
  // During a write walk it shows the word before it is overwritten
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= busy ? rd_word : '0;
    end
  end

  // Access strobe, one cycle per word read or written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      word_strobe <= 1'b0;
    end else begin
      word_strobe <= busy; // R03
    end
  end

  // Address trace; holds the last word between walks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      word_addr <= '0;
    end else if (busy) begin
      word_addr <= addr; // R05
    end
  end

  // Receive gain word, read straight from its fixed slot
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      receive_gain_coeff_word <= '0;
    end else begin
      receive_gain_coeff_word <= mem_r[CRB_ADDR_RX_GAIN]; // R07
    end
  end

  // Receive frequency response, the partner word in the same block
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      receive_freq_response_coeff_word <= '0;
    end else begin
      receive_freq_response_coeff_word <= mem_r[CRB_ADDR_RX_FRESP]; // R07
    end
  end

  // Top coefficient of block 2, fifth step of that block's countdown
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      block3_top_coeff_word <= '0;
    end else begin
      block3_top_coeff_word <= mem_r[CRB_ADDR_BLK3_TOP]; // R08
    end
  end

endmodule // crb_coeff_ram

// File: crb_host.sv
`timescale 1ns/10ps
// Host names a block only and holds the request until an edge where ready is high
module crb_host import crb_pkg::*; (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire logic wr_ready,
  output logic cmd_valid,
  output crb_cmd_t cmd,
  output logic [15:0] wr_data
);
  logic [2:0] w_idx = 3'h7;
  initial {cmd_valid, cmd} = '0;
  // Words streamed top first; each carries its own address below a tag
  assign wr_data = {10'h1a5, cmd.blk, w_idx};
  // Next word only after the edge that consumed this one
  always @(posedge sys_clk) if (wr_ready) w_idx <= w_idx - 3'h1;
  task automatic go(logic w, logic [2:0] b);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= {w, b};
    do @(posedge sys_clk); while (!cmd_ready);
    cmd_valid <= 1'b0;
  endtask
endmodule // crb_host

// File: crb_pkg.sv
package crb_pkg;
  // Memory geometry
  localparam int unsigned CRB_WORDS = 40;
  localparam int unsigned CRB_BLOCKS = 5;
  localparam int unsigned CRB_BLK_WORDS = 8;
  localparam int unsigned CRB_BLK_W = 3;
  localparam int unsigned CRB_IDX_W = 3;
  localparam int unsigned CRB_ADDR_W = CRB_BLK_W + CRB_IDX_W;
  localparam int unsigned CRB_DATA_W = 16;
  // Index countdown limits
  localparam logic [CRB_IDX_W-1:0] CRB_IDX_TOP = 3'h7;
  localparam logic [CRB_IDX_W-1:0] CRB_IDX_BOT = 3'h0;
  // Highest legal block number
  localparam logic [CRB_BLK_W-1:0] CRB_BLK_LAST = 3'h4;
  // Named coefficient locations
  localparam logic [CRB_BLK_W-1:0] CRB_BLK_RX = 3'h4;
  localparam logic [CRB_ADDR_W-1:0] CRB_ADDR_RX_GAIN = 6'h27;
  localparam logic [CRB_ADDR_W-1:0] CRB_ADDR_RX_FRESP = 6'h26;
  localparam logic [CRB_BLK_W-1:0] CRB_BLK_TONE = 3'h2;
  localparam logic [CRB_ADDR_W-1:0] CRB_ADDR_BLK3_TOP = 6'h13;
  // Reset value of stored words
  localparam logic [CRB_DATA_W-1:0] CRB_DATA_RST = 16'h0000;

  // Command from the control interface
  typedef struct packed {
    logic                  wr;
    logic [CRB_BLK_W-1:0]  blk;
  } crb_cmd_t;

  typedef enum logic [1:0] {CRB_IDLE, CRB_RUN} crb_state_t;
endpackage : crb_pkg
